// *** ddw_device.sv ***
// Converter end: word shifter, latch steering and control register
// ============================================================
`timescale 1ns/1ps
`default_nettype none
`include "ddw_regs.svh"
module ddw_device
  import ddw_pkg::*;
(
  // Clock and power-on reset
  input wire logic clk,
  input wire logic reset,
  // Link
  ddw_link_if.dev link,
  // Converter state
  output logic [`DDW_VALUE_BITS-1:0] first_channel_output,
  output logic [`DDW_VALUE_BITS-1:0] second_channel_output,
  output logic [`DDW_VALUE_BITS-1:0] double_buffer,
  output logic speed_fast,
  output logic sleep,
  output ddw_ref_t vsel,
  output logic [11:0] reference_select_control
);
  // ============================================================
  // Pin synchronisers
  logic [1:0] sel_sync;
  logic [1:0] clk_sync;
  logic [1:0] dat_sync;
  logic sel_q;
  logic clk_q;
  always_ff @(posedge clk) begin
    if (reset) begin
      sel_sync <= 2'b11;
      clk_sync <= 2'b11;
      dat_sync <= 2'b00;
      sel_q <= 1'b1;
      clk_q <= 1'b1;
    end else begin
      sel_sync <= {sel_sync[0], link.select_n};
      clk_sync <= {clk_sync[0], link.sclk};
      dat_sync <= {dat_sync[0], link.sdata};
      sel_q <= sel_sync[1];
      clk_q <= clk_sync[1];
    end
  end
  logic sel_n;
  logic sclk_fall;
  logic sclk_rise;
  logic sel_rise;
  assign sel_n = sel_sync[1];
  assign sclk_fall = clk_q & ~clk_sync[1];
  assign sclk_rise = ~clk_q & clk_sync[1];
  assign sel_rise = ~sel_q & sel_sync[1];

  // ============================================================
  // Shift register and bit count
  logic [`DDW_WORD_BITS-1:0] shift_word_register;
  logic [4:0] bit_count;
  logic word_done;
  logic xfer;
  assign word_done = (bit_count == 5'(`DDW_WORD_BITS));
  assign xfer = word_done & (sel_rise | (sclk_rise & ~sel_n));
  always_ff @(posedge clk) begin
    if (reset) begin
      shift_word_register <= 16'h0000;
      bit_count <= 5'h00;
    end else if (sel_n | xfer) begin
      bit_count <= 5'h00;
    end else if (sclk_fall && !word_done) begin
      shift_word_register <= {shift_word_register[`DDW_WORD_BITS-2:0], dat_sync[1]};
      bit_count <= bit_count + 5'h01;
    end
  end

  // ============================================================
  // Word decode
  logic latch_addr_hi;
  logic latch_addr_lo;
  logic speed_bit;
  logic sleep_bit;
  logic [`DDW_VALUE_BITS-1:0] value;
  assign latch_addr_hi = shift_word_register[`DDW_ADDR_HI_BIT];
  assign latch_addr_lo = shift_word_register[`DDW_ADDR_LO_BIT];
  assign speed_bit = shift_word_register[`DDW_SPEED_BIT];
  assign sleep_bit = shift_word_register[`DDW_SLEEP_BIT];
  assign value = shift_word_register[`DDW_VALUE_MSB:`DDW_VALUE_LSB];

  // ============================================================
  // Latches, kept while asleep
  always_ff @(posedge clk) begin
    if (reset) begin
      first_channel_output <= `DDW_LATCH_RESET;
      second_channel_output <= `DDW_LATCH_RESET;
      double_buffer <= `DDW_LATCH_RESET;
    end else if (xfer) begin
      unique case ({latch_addr_hi, latch_addr_lo})
        2'b00: begin
          second_channel_output <= value;
          double_buffer <= value;
        end
        2'b01: double_buffer <= value;
        2'b10: begin
          first_channel_output <= value;
          second_channel_output <= double_buffer;
        end
        2'b11: begin
        end
      endcase
    end
  end

  // Mode bits follow every accepted word; latches untouched
  always_ff @(posedge clk) begin
    if (reset) begin
      speed_fast <= 1'b0;
      sleep <= 1'b0;
    end else if (xfer) begin
      speed_fast <= speed_bit;
      sleep <= sleep_bit;
    end
  end

  // ============================================================
  // Control register
  always_ff @(posedge clk) begin
    if (reset) begin
      reference_select_control <= `DDW_CTRL_RESET;
    end else if (xfer && latch_addr_hi && latch_addr_lo) begin
      reference_select_control <= shift_word_register[`DDW_VALUE_MSB:0];
    end
  end
  assign vsel = ddw_ref_t'(reference_select_control[`DDW_VSEL_HI_BIT:`DDW_VSEL_LO_BIT]);
endmodule : ddw_device
`default_nettype wire

// *** ddw_host.sv ***
// Host end: AXI4-Lite registers driving the serial word link
//
// The AXI4-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "ddw_regs.svh"
module ddw_host
  import ddw_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // AXI4-Lite slave
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Link
  ddw_link_if.host link
);
  // ============================================================
  // Write channel
  logic aw_held;
  logic w_held;
  logic [3:0] aw_q;
  logic [31:0] w_q;
  logic [3:0] ws_q;
  logic [7:0] half_div;
  logic [15:0] word;
  logic start;
  ddw_state_t state;
  logic busy;
  assign busy = (state != DDW_ST_IDLE);
  assign s_axi_awready = ~aw_held & ~s_axi_bvalid;
  assign s_axi_wready = ~w_held & ~s_axi_bvalid;
  logic do_write;
  assign do_write = aw_held & w_held & ~s_axi_bvalid;
  always_ff @(posedge clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_q <= 4'h0;
      w_q <= 32'h0;
      ws_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_q <= s_axi_wdata;
        ws_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= (aw_q == `DDW_OFS_WORD && busy) ? 2'b10 :
          ((aw_q == `DDW_OFS_WORD || aw_q == `DDW_OFS_DIVIDE) ? 2'b00 : 2'b10);
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  assign start = do_write && aw_q == `DDW_OFS_WORD && !busy;
  always_ff @(posedge clk) begin
    if (reset) begin
      half_div <= `DDW_DIVIDE_RESET;
    end else if (do_write && aw_q == `DDW_OFS_DIVIDE && ws_q[0]) begin
      half_div <= (w_q[7:0] < 8'(`DDW_HALF_MIN_CYC)) ? 8'(`DDW_HALF_MIN_CYC) : w_q[7:0];
    end
  end

  // ============================================================
  // Read channel
  assign s_axi_arready = ~s_axi_rvalid;
  always_ff @(posedge clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      unique case (s_axi_araddr)
        `DDW_OFS_WORD: s_axi_rdata <= {16'h0, word};
        `DDW_OFS_STATUS: s_axi_rdata <= {31'h0, busy};
        `DDW_OFS_DIVIDE: s_axi_rdata <= {24'h0, half_div};
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ============================================================
  // Serial sequencer
  logic [7:0] tick;
  logic [4:0] bits_left;
  logic [8:0] gap;
  always_ff @(posedge clk) begin
    if (reset) begin
      state <= DDW_ST_IDLE;
      word <= 16'h0000;
      tick <= 8'h00;
      bits_left <= 5'h00;
      gap <= 9'h000;
      link.select_n <= 1'b1;
      link.sclk <= 1'b1;
      link.sdata <= 1'b0;
    end else begin
      unique case (state)
        DDW_ST_IDLE: begin
          if (start) begin
            word <= w_q[15:0];
            link.select_n <= 1'b0;
            link.sdata <= w_q[15];
            bits_left <= 5'(`DDW_WORD_BITS);
            tick <= half_div;
            gap <= 9'(`DDW_UPDATE_CYC);
            state <= DDW_ST_HIGH;
          end
        end
        DDW_ST_HIGH: begin
          if (gap != 9'h000) gap <= gap - 9'h001;
          if (tick > 8'h01) begin
            tick <= tick - 8'h01;
          end else begin
            link.sclk <= 1'b0;
            tick <= half_div;
            bits_left <= bits_left - 5'h01;
            state <= DDW_ST_LOW;
          end
        end
        DDW_ST_LOW: begin
          if (gap != 9'h000) gap <= gap - 9'h001;
          if (tick > 8'h01) begin
            tick <= tick - 8'h01;
          end else begin
            link.sclk <= 1'b1;
            tick <= half_div;
            if (bits_left == 5'h00) begin
              state <= DDW_ST_GAP;
            end else begin
              word <= {word[14:0], 1'b0};
              link.sdata <= word[14];
              state <= DDW_ST_HIGH;
            end
          end
        end
        DDW_ST_GAP: begin
          link.select_n <= 1'b1;
          if (gap > 9'h001) begin
            gap <= gap - 9'h001;
          end else begin
            state <= DDW_ST_IDLE;
          end
        end
      endcase
    end
  end
endmodule : ddw_host
`default_nettype wire

// *** ddw_link_chk.sv ***
// Wire-level checks on the serial word link
`timescale 1ns/1ps
`default_nettype none
module ddw_link_chk (
  // Clock and reset
  input wire logic clk,
  input wire logic reset,
  // Link
  input wire logic select_n,
  input wire logic sclk,
  input wire logic sdata
);
  logic [4:0] n_fall;
  logic [7:0] gap;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  // Clock falls within the current frame
  always_ff @(posedge clk) begin
    if (reset || select_n) n_fall <= 5'h00;
    else if ($fell(sclk)) n_fall <= n_fall + 5'h01;
  end
  // Cycles since the last frame start, saturating
  always_ff @(posedge clk) begin
    if (reset) gap <= 8'hff;
    else if ($fell(select_n)) gap <= 8'h01;
    else if (gap != 8'hff) gap <= gap + 8'h01;
  end
  data_at_fall_a: assert property ($fell(sclk) |-> $stable(sdata) ##1 $stable(sdata))
    else $error("data moved around clock fall");
  idle_high_a: assert property (select_n |-> sclk)
    else $error("clock not high while deselected");
  low_width_a: assert property ($fell(sclk) |-> !sclk [*5])
    else $error("clock low phase too short");
  high_width_a: assert property ($rose(sclk) && !select_n |-> sclk [*5])
    else $error("clock high phase too short");
  word_len_a: assert property ($rose(select_n) |-> n_fall == 5'h10)
    else $error("frame not sixteen bits");
  update_gap_a: assert property ($fell(select_n) |-> gap >= 8'ha0)
    else $error("frames closer than update period");
  start_high_a: assert property ($fell(select_n) |-> sclk ##1 sclk)
    else $error("clock low at frame start");
  end_rise_a: assert property ($rose(select_n) |-> sclk && $past(sclk))
    else $error("frame ended without clock rise");
  word_cov: cover property ($rose(select_n) && n_fall == 5'h10);
  fast_clk_cov: cover property ($fell(sclk) ##5 sclk);
  back_cov: cover property ($fell(select_n) && gap < 8'hff);
endmodule : ddw_link_chk
`default_nettype wire

// *** ddw_link_if.sv ***
// Three-wire serial word link between host and converter
`timescale 1ns/1ps
`default_nettype none
interface ddw_link_if;
  logic select_n;
  logic sclk;
  logic sdata;
  modport host (output select_n, output sclk, output sdata);
  modport dev (input select_n, input sclk, input sdata);
endinterface : ddw_link_if
`default_nettype wire

// *** ddw_pkg.sv ***
// Types for the serial word link: reference select for the converter end, sequencer states for the host end
`default_nettype none
package ddw_pkg;
  typedef enum logic [1:0] {
    DDW_REF_EXT0 = 2'b00,
    DDW_REF_1V024 = 2'b01,
    DDW_REF_2V048 = 2'b10,
    DDW_REF_EXT1 = 2'b11
  } ddw_ref_t;
  typedef enum logic [1:0] {
    DDW_ST_IDLE = 2'b00,
    DDW_ST_LOW = 2'b01,
    DDW_ST_HIGH = 2'b10,
    DDW_ST_GAP = 2'b11
  } ddw_state_t;
endpackage : ddw_pkg
`default_nettype wire

// *** ddw_regs.svh ***
// Constants for the dual converter serial word link
`ifndef DDW_REGS_SVH
`define DDW_REGS_SVH
// Word layout
`define DDW_WORD_BITS 16
`define DDW_ADDR_HI_BIT 15
`define DDW_SPEED_BIT 14
`define DDW_SLEEP_BIT 13
`define DDW_ADDR_LO_BIT 12
`define DDW_VALUE_MSB 11
`define DDW_VALUE_LSB 2
`define DDW_VALUE_BITS 10
`define DDW_VSEL_HI_BIT 1
`define DDW_VSEL_LO_BIT 0
// Reset values
`define DDW_LATCH_RESET 10'h000
`define DDW_CTRL_RESET 12'h000
// Host register map (AXI4-Lite byte offsets)
`define DDW_OFS_WORD 4'h0
`define DDW_OFS_STATUS 4'h4
`define DDW_OFS_DIVIDE 4'h8
// Status fields
`define DDW_STAT_BUSY_BIT 0
// Link timing
`define DDW_CLK_MHZ 200
`define DDW_SCLK_MAX_MHZ 20
`define DDW_UPDATE_NS 800
`define DDW_HALF_MIN_CYC ((`DDW_CLK_MHZ + 2 * `DDW_SCLK_MAX_MHZ - 1) / (2 * `DDW_SCLK_MAX_MHZ))
`define DDW_UPDATE_CYC ((`DDW_UPDATE_NS * `DDW_CLK_MHZ + 999) / 1000)
`define DDW_DIVIDE_RESET 8'h08
`endif

// *** tb.sv ***
// Self-checking bench for host and converter ends
`timescale 1ns/1ps
`default_nettype none
module tb
  import ddw_pkg::*;
;
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic [3:0] awaddr = 4'h0, araddr = 4'h0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = 32'h0, rdata, d;
  logic awready, wready, bvalid, arready, rvalid, fast, sleep;
  logic [1:0] bresp, rresp;
  logic [9:0] la, lb, lbuf, la2, lb2;
  logic [11:0] ctrl;
  ddw_ref_t vsel;
  int n_mismatch = 0, checks = 0, k;
  ddw_link_if link ();
  ddw_link_if link2 ();
  always #2.5 clk = ~clk;
  ddw_host ddw_host_i (.clk(clk), .reset(reset), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .link(link.host));
  ddw_device ddw_device_i (.clk(clk), .reset(reset), .link(link.dev),
    .first_channel_output(la), .second_channel_output(lb), .double_buffer(lbuf),
    .speed_fast(fast), .sleep(sleep), .vsel(vsel), .reference_select_control(ctrl));
  // Second converter end, driven bit by bit from here
  ddw_device ddw_device_i2 (.clk(clk), .reset(reset), .link(link2.dev),
    .first_channel_output(la2), .second_channel_output(lb2), .double_buffer(),
    .speed_fast(), .sleep(), .vsel(), .reference_select_control());
  ddw_link_chk ddw_link_chk_i (.clk(clk), .reset(reset), .select_n(link.select_n),
    .sclk(link.sclk), .sdata(link.sdata));
  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task automatic tmo();
    n_mismatch++;
    $display("Error at %0t: wait ran out", $time);
    wrap_up();
  endtask : tmo
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
    int i;
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (i == 300) tmo();
    bready <= 1'b0;
    chk(bresp, er);
    @(posedge clk);
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v, input logic [1:0] er);
    int i;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (i = 0; i < 300; i++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (i == 300) tmo();
    rready <= 1'b0;
    v = rdata;
    chk(rresp, er);
    @(posedge clk);
  endtask : axi_rd
  // One word through the host, then wait for idle
  task automatic send(input logic [15:0] w);
    axi_wr(4'h0, {16'h0000, w}, 2'b00);
    idle();
  endtask : send
  // Poll status until the link is idle
  task automatic idle();
    int i;
    for (i = 0; i < 100; i++) begin
      axi_rd(4'h4, d, 2'b00);
      if (!d[0]) break;
    end
    if (i == 100) tmo();
    repeat (8) @(posedge clk);
  endtask : idle
  task automatic dev(input logic [9:0] a, input logic [9:0] b, input logic [9:0] db);
    chk(la, a);
    chk(lb, b);
    chk(lbuf, db);
  endtask : dev
  // First n bits of w on the second link, 80 ns clock; cut drops the last rise
  task automatic bang(input logic [15:0] w, input int n, input logic en, input logic cut);
    link2.select_n <= ~en;
    for (k = 15; k > 15 - n; k--) begin
      link2.sdata <= w[k];
      repeat (8) @(posedge clk);
      link2.sclk <= 1'b0;
      repeat (8) @(posedge clk);
      if (!cut || k > 16 - n) link2.sclk <= 1'b1;
    end
    repeat (8) @(posedge clk);
    link2.select_n <= 1'b1;
    link2.sdata <= ~w[16 - n];
    repeat (8) @(posedge clk);
    link2.sclk <= 1'b1;
    repeat (192) @(posedge clk);
  endtask : bang
  initial begin
    link2.select_n = 1'b1;
    link2.sclk = 1'b1;
    link2.sdata = 1'b0;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    dev(10'h000, 10'h000, 10'h000);
    axi_rd(4'hc, d, 2'b10);
    chk(d, 32'h0);
    axi_wr(4'hc, 32'h1, 2'b10);
    axi_wr(4'h8, 32'h5, 2'b00);
    axi_rd(4'h8, d, 2'b00);
    chk(d[7:0], 32'h5);
    $display("Test registers done");
    send(16'h0fff);
    dev(10'h000, 10'h3ff, 10'h3ff);
    chk(ctrl, 32'h0);
    send(16'h1554);
    dev(10'h000, 10'h3ff, 10'h155);
    send(16'hcaa8);
    dev(10'h2aa, 10'h155, 10'h155);
    chk(fast, 32'h1);
    $display("Test latches done");
    for (k = 0; k < 4; k++) begin
      send({4'hd, 10'h0ab, k[1:0]});
      chk(ctrl, {20'h0, 10'h0ab, k[1:0]});
      chk(vsel, k);
    end
    dev(10'h2aa, 10'h155, 10'h155);
    send(16'hf000);
    chk(sleep, 32'h1);
    dev(10'h2aa, 10'h155, 10'h155);
    send(16'h5004);
    chk(sleep, 32'h0);
    dev(10'h2aa, 10'h155, 10'h001);
    send(16'h8ffc);
    dev(10'h3ff, 10'h001, 10'h001);
    chk(fast, 32'h0);
    axi_wr(4'h0, 32'h00008004, 2'b00);
    axi_wr(4'h0, 32'h00000000, 2'b10);
    idle();
    dev(10'h001, 10'h001, 10'h001);
    $display("Test options done");
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    repeat (4) @(posedge clk);
    dev(10'h000, 10'h000, 10'h000);
    chk(ctrl, 32'h0);
    axi_rd(4'h8, d, 2'b00);
    chk(d, 32'h8);
    $display("Test reset done");
    bang(16'h03fc, 16, 1'b1, 1'b0);
    chk(lb2, 10'h0ff);
    bang(16'h8ffc, 8, 1'b1, 1'b0);
    chk(la2, 10'h000);
    chk(lb2, 10'h0ff);
    bang(16'h8ffc, 16, 1'b0, 1'b0);
    chk(la2, 10'h000);
    bang(16'h8ffc, 16, 1'b1, 1'b0);
    chk(la2, 10'h3ff);
    bang(16'h0004, 16, 1'b1, 1'b1);
    chk(lb2, 10'h001);
    chk(la2, 10'h3ff);
    $display("Test link done");
    wrap_up();
  end
endmodule : tb
`default_nettype wire
